// ### sbw_pkg.sv
// Purpose: constants and types for the standby entry and wake controller
// Assumes: AXI4-Lite register access, 32-bit data, one word per register
// Notes: register indices are printed offsets; byte address is index * 4
package sbw_pkg;

    // ==========================================================
    // register indices and byte addresses
    localparam logic [23:0] SBW_IDX_STBY_CTRL = 24'hfffdc6;
    localparam logic [23:0] SBW_IDX_DEEP_CTRL = 24'hfffe70;
    localparam logic [23:0] SBW_IDX_DEEP_WAIT = 24'hfffe71;
    localparam logic [23:0] SBW_IDX_WAKE_EN = 24'hfffe72;
    localparam logic [23:0] SBW_IDX_WAKE_FLAG = 24'hfffe73;
    localparam logic [23:0] SBW_IDX_WAKE_EDGE = 24'hfffe74;
    localparam logic [23:0] SBW_IDX_IRQ_STAT = 24'hfffe80;
    localparam logic [23:0] SBW_IDX_IRQ_MASK = 24'hfffe81;
    localparam logic [23:0] SBW_IDX_STATE = 24'hfffe82;
    localparam int SBW_ADDR_SHIFT = 2;

    // ==========================================================
    // field positions and writable masks
    localparam int SBW_STANDBY_SELECT_BIT = 15;
    localparam int SBW_SETTLE_LSB = 8;
    localparam int SBW_DEEP_SELECT_BIT = 7;
    localparam int SBW_NMI_EDGE_BIT = 7;
    localparam int SBW_NMI_FLAG_BIT = 7;
    localparam logic [15:0] SBW_STBY_WMASK = 16'h9f00;
    localparam logic [7:0] SBW_DEEP_CTRL_WMASK = 8'h80;
    localparam logic [7:0] SBW_DEEP_WAIT_WMASK = 8'h3f;
    localparam logic [7:0] SBW_EDGE_WMASK = 8'h8f;
    localparam logic [7:0] SBW_WAKE_EN_WMASK = 8'h0f;
    localparam logic [7:0] SBW_FLAG_MASK = 8'h8f;

    // ==========================================================
    // wait codes and counts
    localparam logic [4:0] SBW_SETTLE_CODE_262K = 5'h0e;
    localparam logic [5:0] SBW_DEEP_CODE_131K = 6'h0d;
    localparam int SBW_CNT_W = 20;
    localparam int SBW_NPIN = 5;
    localparam int SBW_NEV = 4;

    // ==========================================================
    // interrupt event bits
    localparam int SBW_EV_STANDBY = 0;
    localparam int SBW_EV_DEEP = 1;
    localparam int SBW_EV_RESUME = 2;
    localparam int SBW_EV_WAKE_PIN = 3;

    localparam logic [1:0] SBW_RESP_OKAY = 2'h0;
    localparam logic [1:0] SBW_RESP_SLVERR = 2'h2;

    // ==========================================================
    // state machine
    typedef enum logic [4:0] {
        SBW_ST_RUN = 5'h01,
        SBW_ST_SLEEP = 5'h02,
        SBW_ST_STANDBY = 5'h04,
        SBW_ST_DEEP = 5'h08,
        SBW_ST_SETTLE = 5'h10
    } sbw_state_e;

    typedef struct packed {
        logic run;
        logic sleeping;
        logic standby;
        logic deep_standby;
        logic settling;
    } sbw_status_s;

    typedef struct packed {
        sbw_state_e st;
        logic [SBW_CNT_W-1:0] cnt;
        logic [15:0] stby_ctrl;
        logic [7:0] deep_ctrl;
        logic [7:0] deep_wait;
        logic [7:0] wake_en;
        logic [7:0] wake_flag;
        logic [7:0] flag_seen;
        logic [7:0] wake_edge;
        logic [SBW_NEV-1:0] irq_stat;
        logic [SBW_NEV-1:0] irq_mask;
        logic [SBW_NPIN-1:0] sync1;
        logic [SBW_NPIN-1:0] sync2;
        logic [SBW_NPIN-1:0] sync3;
        logic aw_hold;
        logic [31:0] aw_addr;
        logic w_hold;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } sbw_state_s;

    localparam sbw_state_s SBW_STATE_RST = '{st: SBW_ST_RUN, sync1: '1,
        sync2: '1, sync3: '1, default: '0};

endpackage

// ### sbw_standby_wake.sv
// Purpose: standby entry decision and wake settling wait for the cpu
// Assumes: sleep, release and subclock requests come from aclk logic
// Notes: wake pins are asynchronous and pass a two-stage synchroniser
//
// Operation
// - On wake from deep standby the cpu is held for the deep wait code, 001101 meaning 131072 cycles.
// - With standby_select (bit 15) set, a sleep request enters software standby, not plain sleep.
// - standby_select keeps its value across wake; only a software write of 0 clears it.
// - The five-bit settle code sets the wait after standby wake and subclock-to-main switch, 01110 meaning 262144 cycles.
// - With standby_select set, no release pending and deep_standby_select (bit 7) set, sleep enters deep standby.
// - deep_standby_select stays set after wake from deep standby; only a software write of 0 clears it.
// - An edge-select bit of 0 makes its wake pin detect falling edges.
// - A wake flag sets on its wake event and clears only on a write of 0 after it was read as 1.
//
// Our own choice: the AXI4-Lite register port.
`timescale 1ns/1ns

module sbw_standby_wake
    import sbw_pkg::*;
#(
    parameter int unsigned WAIT_SETTLE_CYCLES = 262144,
    parameter int unsigned WAIT_DEEP_CYCLES = 131072,
    parameter int unsigned WAIT_OTHER_CYCLES = 64
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write address
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] awaddr,
    input wire logic [2:0] awprot,
    // axi4-lite write data
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    // axi4-lite write response
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    // axi4-lite read address
    input wire logic arvalid,
    output logic arready,
    input wire logic [31:0] araddr,
    input wire logic [2:0] arprot,
    // axi4-lite read data
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    // cpu side
    input wire logic sleep_req,
    input wire logic release_pending,
    input wire logic subclk_to_main_req,
    // wake pins, asynchronous
    input wire logic nmi_pin,
    input wire logic [3:0] wake_pin,
    // status and interrupt
    output sbw_status_s status,
    output logic irq
);

    // ==========================================================
    // helpers
    function automatic logic [31:0] byte_addr(input logic [23:0] idx);
        byte_addr = {6'h00, idx, 2'h0};
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] val,
                                          input logic [3:0] strb,
                                          input logic [31:0] wmask);
        logic [31:0] m;
        m = '0;
        for (int i = 0; i < 4; i++) begin
            m[i*8 +: 8] = {8{strb[i]}};
        end
        m = m & wmask;
        merge = (old & ~m) | (val & m);
    endfunction

    function automatic logic [SBW_CNT_W-1:0] settle_load(
        input logic [4:0] code);
        if (code == SBW_SETTLE_CODE_262K) begin
            settle_load = SBW_CNT_W'(WAIT_SETTLE_CYCLES - 1);
        end else begin
            settle_load = SBW_CNT_W'(WAIT_OTHER_CYCLES - 1);
        end
    endfunction

    function automatic logic [SBW_CNT_W-1:0] deep_load(
        input logic [5:0] code);
        if (code == SBW_DEEP_CODE_131K) begin
            deep_load = SBW_CNT_W'(WAIT_DEEP_CYCLES - 1);
        end else begin
            deep_load = SBW_CNT_W'(WAIT_OTHER_CYCLES - 1);
        end
    endfunction

    // ==========================================================
    // state
    sbw_state_s q;
    sbw_state_s next_q;

    logic [SBW_NPIN-1:0] edge_sel;
    logic [SBW_NPIN-1:0] pin_event;
    logic [4:0] settle_code;
    logic [5:0] deep_code;
    logic stby_sel;
    logic deep_sel;
    logic deep_wake;
    logic write_go;
    logic [31:0] wr;
    logic [7:0] flag_set;
    logic [7:0] flag_clr;
    logic [SBW_NEV-1:0] ev;

    // ==========================================================
    // handshakes and outputs
    assign awready = !q.aw_hold && !q.bvalid;
    assign wready = !q.w_hold && !q.bvalid;
    assign arready = !q.rvalid;
    assign bvalid = q.bvalid;
    assign bresp = q.bresp;
    assign rvalid = q.rvalid;
    assign rdata = q.rdata;
    assign rresp = q.rresp;
    assign irq = |(q.irq_stat & q.irq_mask);
    assign status.run = (q.st == SBW_ST_RUN);
    assign status.sleeping = (q.st == SBW_ST_SLEEP);
    assign status.standby = (q.st == SBW_ST_STANDBY);
    assign status.deep_standby = (q.st == SBW_ST_DEEP);
    assign status.settling = (q.st == SBW_ST_SETTLE);

    // ==========================================================
    // next state
    always_comb begin
        next_q = q;
        ev = '0;

        // pin synchroniser and edge detect
        // syncs reset high, the idle level, so no false edge
        next_q.sync1 = {nmi_pin, wake_pin};
        next_q.sync2 = q.sync1;
        next_q.sync3 = q.sync2;
        edge_sel = {q.wake_edge[SBW_NMI_EDGE_BIT], q.wake_edge[3:0]};
        for (int i = 0; i < SBW_NPIN; i++) begin
            pin_event[i] = edge_sel[i] ? (q.sync2[i] && !q.sync3[i])
                                       : (!q.sync2[i] && q.sync3[i]);
        end
        flag_set = {pin_event[4], 3'h0, pin_event[3:0]};
        deep_wake = pin_event[4] || |(pin_event[3:0] & q.wake_en[3:0]);
        if (|pin_event) begin
            ev[SBW_EV_WAKE_PIN] = 1'b1;
        end

        settle_code = q.stby_ctrl[SBW_SETTLE_LSB +: 5];
        deep_code = q.deep_wait[5:0];
        stby_sel = q.stby_ctrl[SBW_STANDBY_SELECT_BIT];
        deep_sel = q.deep_ctrl[SBW_DEEP_SELECT_BIT];

        // power state sequencing; control bits untouched on wake
        case (q.st)
            SBW_ST_RUN: begin
                if (sleep_req) begin
                    if (!stby_sel) begin
                        next_q.st = SBW_ST_SLEEP;
                    end else if (!release_pending && deep_sel) begin
                        next_q.st = SBW_ST_DEEP;
                        ev[SBW_EV_DEEP] = 1'b1;
                    end else begin
                        next_q.st = SBW_ST_STANDBY;
                        ev[SBW_EV_STANDBY] = 1'b1;
                    end
                end else if (subclk_to_main_req) begin
                    next_q.st = SBW_ST_SETTLE;
                    next_q.cnt = settle_load(settle_code);
                end
            end
            SBW_ST_SLEEP: begin
                if (release_pending || deep_wake) begin
                    next_q.st = SBW_ST_RUN;
                end
            end
            SBW_ST_STANDBY: begin
                if (release_pending || deep_wake) begin
                    next_q.st = SBW_ST_SETTLE;
                    next_q.cnt = settle_load(settle_code);
                end
            end
            SBW_ST_DEEP: begin
                if (deep_wake) begin
                    next_q.st = SBW_ST_SETTLE;
                    next_q.cnt = deep_load(deep_code);
                end
            end
            SBW_ST_SETTLE: begin
                if (q.cnt == '0) begin
                    next_q.st = SBW_ST_RUN;
                    ev[SBW_EV_RESUME] = 1'b1;
                end else begin
                    next_q.cnt = q.cnt - 1'b1;
                end
            end
            default: begin
                next_q.st = SBW_ST_RUN;
            end
        endcase

        // write address and data capture, either order
        if (awvalid && awready) begin
            next_q.aw_hold = 1'b1;
            next_q.aw_addr = awaddr;
        end
        if (wvalid && wready) begin
            next_q.w_hold = 1'b1;
            next_q.w_data = wdata;
            next_q.w_strb = wstrb;
        end
        if (q.bvalid && bready) begin
            next_q.bvalid = 1'b0;
        end

        // register write
        write_go = q.aw_hold && q.w_hold && !q.bvalid;
        wr = q.w_data;
        flag_clr = '0;
        if (write_go) begin
            next_q.aw_hold = 1'b0;
            next_q.w_hold = 1'b0;
            next_q.bvalid = 1'b1;
            next_q.bresp = SBW_RESP_OKAY;
            case (q.aw_addr)
                byte_addr(SBW_IDX_STBY_CTRL): begin
                    next_q.stby_ctrl = 16'(merge({16'h0000, q.stby_ctrl},
                        wr, q.w_strb,
                        {16'h0000, SBW_STBY_WMASK}));
                end
                byte_addr(SBW_IDX_DEEP_CTRL): begin
                    next_q.deep_ctrl = 8'(merge({24'h0, q.deep_ctrl},
                        wr, q.w_strb,
                        {24'h0, SBW_DEEP_CTRL_WMASK}));
                end
                byte_addr(SBW_IDX_DEEP_WAIT): begin
                    next_q.deep_wait = 8'(merge({24'h0, q.deep_wait}, wr,
                        q.w_strb, {24'h0, SBW_DEEP_WAIT_WMASK}));
                end
                byte_addr(SBW_IDX_WAKE_EN): begin
                    next_q.wake_en = 8'(merge({24'h0, q.wake_en}, wr,
                        q.w_strb, {24'h0, SBW_WAKE_EN_WMASK}));
                end
                byte_addr(SBW_IDX_WAKE_EDGE): begin
                    next_q.wake_edge = 8'(merge({24'h0, q.wake_edge}, wr,
                        q.w_strb, {24'h0, SBW_EDGE_WMASK}));
                end
                byte_addr(SBW_IDX_WAKE_FLAG): begin
                    if (q.w_strb[0]) begin
                        flag_clr = ~wr[7:0] & q.flag_seen & SBW_FLAG_MASK;
                    end
                end
                byte_addr(SBW_IDX_IRQ_STAT): begin
                    if (q.w_strb[0]) begin
                        next_q.irq_stat = q.irq_stat & ~wr[SBW_NEV-1:0];
                    end
                end
                byte_addr(SBW_IDX_IRQ_MASK): begin
                    if (q.w_strb[0]) begin
                        next_q.irq_mask = wr[SBW_NEV-1:0];
                    end
                end
                byte_addr(SBW_IDX_STATE): begin
                end
                default: begin
                    next_q.bresp = SBW_RESP_SLVERR;
                end
            endcase
        end

        // wake flags: clear only after read as 1, set wins
        next_q.flag_seen = q.flag_seen & ~flag_clr;
        next_q.wake_flag = (q.wake_flag & ~flag_clr) | flag_set;
        next_q.irq_stat = next_q.irq_stat | ev;

        // register read
        if (q.rvalid && rready) begin
            next_q.rvalid = 1'b0;
        end
        if (arvalid && arready) begin
            next_q.rvalid = 1'b1;
            next_q.rresp = SBW_RESP_OKAY;
            next_q.rdata = '0;
            case (araddr)
                byte_addr(SBW_IDX_STBY_CTRL): begin
                    next_q.rdata = {16'h0000, q.stby_ctrl};
                end
                byte_addr(SBW_IDX_DEEP_CTRL): begin
                    next_q.rdata = {24'h0, q.deep_ctrl};
                end
                byte_addr(SBW_IDX_DEEP_WAIT): begin
                    next_q.rdata = {24'h0, q.deep_wait};
                end
                byte_addr(SBW_IDX_WAKE_EN): begin
                    next_q.rdata = {24'h0, q.wake_en};
                end
                byte_addr(SBW_IDX_WAKE_EDGE): begin
                    next_q.rdata = {24'h0, q.wake_edge};
                end
                byte_addr(SBW_IDX_WAKE_FLAG): begin
                    next_q.rdata = {24'h0, q.wake_flag};
                    next_q.flag_seen = next_q.flag_seen | q.wake_flag;
                end
                byte_addr(SBW_IDX_IRQ_STAT): begin
                    next_q.rdata = {{(32-SBW_NEV){1'b0}}, q.irq_stat};
                end
                byte_addr(SBW_IDX_IRQ_MASK): begin
                    next_q.rdata = {{(32-SBW_NEV){1'b0}}, q.irq_mask};
                end
                byte_addr(SBW_IDX_STATE): begin
                    next_q.rdata = {7'h00, q.cnt, q.st};
                end
                default: begin
                    next_q.rresp = SBW_RESP_SLVERR;
                end
            endcase
        end
    end

    // ==========================================================
    // registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q <= SBW_STATE_RST;
        end else begin
            q <= next_q;
        end
    end

endmodule // sbw_standby_wake

// ### sbw_standby_wake_asserts.sv
// Purpose: temporal checks on standby entry and wake settling
// Assumes: status is a one-hot decode of the state flops
// Notes: settle length is checked against the set of legal waits
`timescale 1ns/1ns
module sbw_standby_wake_asserts
    import sbw_pkg::*;
#(
    parameter int unsigned WAIT_SETTLE_CYCLES = 262144,
    parameter int unsigned WAIT_DEEP_CYCLES = 131072,
    parameter int unsigned WAIT_OTHER_CYCLES = 64
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // cpu side and state
    input wire logic sleep_req,
    input wire logic release_pending,
    input wire sbw_status_s status
);
    // ==========================================================
    // settle length counter
    localparam logic [SBW_CNT_W-1:0] NS = SBW_CNT_W'(WAIT_SETTLE_CYCLES);
    localparam logic [SBW_CNT_W-1:0] ND = SBW_CNT_W'(WAIT_DEEP_CYCLES);
    localparam logic [SBW_CNT_W-1:0] NO = SBW_CNT_W'(WAIT_OTHER_CYCLES);
    logic [SBW_CNT_W-1:0] n;
    logic dp;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            n <= '0;
            dp <= 1'b0;
        end else begin
            n <= status.settling ? n + 1'b1 : '0;
            dp <= status.deep_standby || (dp && status.settling);
        end
    end
    // ==========================================================
    // properties
    default clocking @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    a_settle_length: assert property ($fell(status.settling) |->
        (dp ? (n == ND || n == NO) : (n == NS || n == NO)))
        else $error("settle wait length wrong");
    a_deep_entry: assert property ($rose(status.deep_standby) |->
        $past(sleep_req) && !$past(release_pending) && $past(status.run))
        else $error("deep standby entered without cause");
    a_pending_blocks: assert property (status.run && sleep_req &&
        release_pending |=> !status.deep_standby)
        else $error("deep standby entered while release pending");
    a_standby_entry: assert property ($rose(status.standby) |->
        $past(sleep_req) && $past(status.run))
        else $error("standby entered without sleep");
    a_sleep_leaves: assert property (status.run && sleep_req |=>
        !status.run) else $error("sleep ignored while running");
    a_settle_exit: assert property (status.settling |=>
        status.settling || status.run) else $error("bad exit from settle");
    a_deep_holds: assert property (status.deep_standby |=>
        status.deep_standby || status.settling)
        else $error("deep standby left without settle");
    a_standby_holds: assert property (status.standby |=>
        status.standby || status.settling)
        else $error("standby left without settle");
    c_deep: cover property ($rose(status.deep_standby));
    c_standby: cover property ($rose(status.standby));
    c_resume: cover property ($fell(status.settling));
endmodule // sbw_standby_wake_asserts

bind sbw_standby_wake sbw_standby_wake_asserts #(
    .WAIT_SETTLE_CYCLES(WAIT_SETTLE_CYCLES),
    .WAIT_DEEP_CYCLES(WAIT_DEEP_CYCLES),
    .WAIT_OTHER_CYCLES(WAIT_OTHER_CYCLES)
) chk_u (.aclk(aclk), .aresetn(aresetn), .sleep_req(sleep_req),
    .release_pending(release_pending), .status(status));

// ### sbw_core_model.sv
// Purpose: processor core model issuing sleep and release requests
// Assumes: sleep and switch requests leave the core only while running
// Notes: one cycle from bench command to block input
`timescale 1ns/1ns
module sbw_core_model
    import sbw_pkg::*;
(
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // bench commands
    input wire logic do_sleep,
    input wire logic do_switch,
    input wire logic pend,
    // block side
    input wire sbw_status_s status,
    output logic sleep_req,
    output logic release_pending,
    output logic subclk_to_main_req
);
    // ==========================================================
    // request drivers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sleep_req <= 1'b0;
            release_pending <= 1'b0;
            subclk_to_main_req <= 1'b0;
        end else begin
            sleep_req <= do_sleep && status.run;
            release_pending <= pend;
            subclk_to_main_req <= do_switch && status.run;
        end
    end
endmodule // sbw_core_model

// ### tb.sv
// Purpose: self-checking bench for standby entry and wake
// Assumes: waits shortened to 20, 10 and 6 cycles
// Notes: registers reached through axi4-lite tasks
`timescale 1ns/1ns
module tb
    import sbw_pkg::*;
;
    localparam int WS = 20;
    localparam int WD = 10;
    // ==========================================================
    // signals
    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic awready, wready, bvalid, arready, rvalid, irq, nmi_pin;
    logic do_sleep, do_switch, pend, sleep_req, release_pending, sub_req;
    logic [31:0] awaddr, wdata, araddr, rdata, rd;
    logic [3:0] wake_pin;
    logic [1:0] bresp, rresp, bs, rs;
    sbw_status_s status;
    int err_count = 0;
    int cmp_count = 0;
    int cyc = 0;
    logic [23:0] idx_t [4] = '{SBW_IDX_STBY_CTRL, SBW_IDX_DEEP_CTRL,
        SBW_IDX_DEEP_WAIT, SBW_IDX_WAKE_EDGE};
    logic [31:0] msk_t [4] = '{32'(SBW_STBY_WMASK),
        32'(SBW_DEEP_CTRL_WMASK), 32'(SBW_DEEP_WAIT_WMASK),
        32'(SBW_EDGE_WMASK)};
    // ==========================================================
    // instances
    sbw_standby_wake #(.WAIT_SETTLE_CYCLES(WS), .WAIT_DEEP_CYCLES(WD),
        .WAIT_OTHER_CYCLES(6)) dut_u (
        .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid),
        .awready(awready), .awaddr(awaddr), .awprot(3'h0),
        .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(4'hf),
        .bvalid(bvalid), .bready(bready), .bresp(bresp),
        .arvalid(arvalid), .arready(arready), .araddr(araddr),
        .arprot(3'h0), .rvalid(rvalid), .rready(rready), .rdata(rdata),
        .rresp(rresp), .sleep_req(sleep_req),
        .release_pending(release_pending), .subclk_to_main_req(sub_req),
        .nmi_pin(nmi_pin), .wake_pin(wake_pin), .status(status), .irq(irq));
    sbw_core_model core_u (.aclk(aclk), .aresetn(aresetn),
        .do_sleep(do_sleep), .do_switch(do_switch), .pend(pend),
        .status(status), .sleep_req(sleep_req),
        .release_pending(release_pending), .subclk_to_main_req(sub_req));
    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_count++;
            conclude();
        end
    end
    // ==========================================================
    // common tasks
    task automatic conclude();
        $display("compares %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e,
        input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            err_count++;
            $display("FAIL %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [23:0] idx, input logic [31:0] d);
        logic a = 1'b0, w = 1'b0, b = 1'b0;
        @(posedge aclk);
        awaddr <= 32'({idx, 2'b00});
        wdata <= d;
        {awvalid, wvalid, bready} <= 3'b111;
        while (!b) begin
            @(posedge aclk);
            b = a && w && bvalid;
            if (b) bs = bresp;
            if (b) bready <= 1'b0;
            if (!a && awready) awvalid <= 1'b0;
            a = a || awready;
            if (!w && wready) wvalid <= 1'b0;
            w = w || wready;
        end
    endtask
    task automatic rd_reg(input logic [23:0] idx);
        logic a = 1'b0, b = 1'b0;
        @(posedge aclk);
        araddr <= 32'({idx, 2'b00});
        {arvalid, rready} <= 2'b11;
        while (!b) begin
            @(posedge aclk);
            b = a && rvalid;
            if (b) rd = rdata;
            if (b) rs = rresp;
            if (b) rready <= 1'b0;
            if (!a && arready) arvalid <= 1'b0;
            a = a || arready;
        end
    endtask
    task automatic measure(input int n_exp);
        int n = 0;
        while (status.settling !== 1'b1) @(posedge aclk);
        while (status.settling === 1'b1) begin
            @(posedge aclk);
            n++;
        end
        chk("settle cycles", 32'(n_exp), 32'(n));
        chk("resumed", 32'h1, 32'(status.run));
    endtask
    task automatic sleep_go();
        @(posedge aclk);
        do_sleep <= 1'b1;
        @(posedge aclk);
        do_sleep <= 1'b0;
    endtask
    // ==========================================================
    // scenarios
    task automatic t_regs();
        for (int i = 0; i < 4; i++) begin
            rd_reg(idx_t[i]);
            chk("reset value", 32'h0, rd);
            wr(idx_t[i], 32'hffffffff);
            chk("write okay", 32'(SBW_RESP_OKAY), 32'(bs));
            rd_reg(idx_t[i]);
            chk("writable bits", msk_t[i], rd);
            chk("read okay", 32'(SBW_RESP_OKAY), 32'(rs));
            wr(idx_t[i], 32'h0);
        end
        rd_reg(24'hfffe90);
        chk("unmapped read", 32'(SBW_RESP_SLVERR), 32'(rs));
        wr(24'hfffe90, 32'h1);
        chk("unmapped write", 32'(SBW_RESP_SLVERR), 32'(bs));
        $display("test t_regs done");
    endtask
    task automatic t_standby();
        logic [31:0] v = {16'h0, 1'b1, 2'b0, SBW_SETTLE_CODE_262K, 8'h0};
        wr(SBW_IDX_STBY_CTRL, v);
        sleep_go();
        repeat (3) @(posedge aclk);
        chk("standby entered", 32'h1, 32'(status.standby));
        @(posedge aclk);
        pend <= 1'b1;
        @(posedge aclk);
        pend <= 1'b0;
        measure(WS);
        rd_reg(SBW_IDX_STBY_CTRL);
        chk("select kept", v, rd);
        $display("test t_standby done");
    endtask
    task automatic t_deep();
        wr(SBW_IDX_DEEP_CTRL, 32'h80);
        wr(SBW_IDX_DEEP_WAIT, 32'(SBW_DEEP_CODE_131K));
        @(posedge aclk);
        pend <= 1'b1;
        sleep_go();
        measure(WS);
        @(posedge aclk);
        pend <= 1'b0;
        sleep_go();
        repeat (3) @(posedge aclk);
        chk("deep entered", 32'h1, 32'(status.deep_standby));
        rd_reg(SBW_IDX_STATE);
        chk("state deep", 32'(SBW_ST_DEEP), rd);
        nmi_pin <= 1'b0;
        measure(WD);
        rd_reg(SBW_IDX_DEEP_CTRL);
        chk("deep select kept", 32'h80, rd);
        wr(SBW_IDX_WAKE_FLAG, 32'h0);
        rd_reg(SBW_IDX_WAKE_FLAG);
        chk("flag before read", 32'h80, rd);
        wr(SBW_IDX_WAKE_FLAG, 32'h0);
        nmi_pin <= 1'b1;
        repeat (5) @(posedge aclk);
        rd_reg(SBW_IDX_WAKE_FLAG);
        chk("flag cleared", 32'h0, rd);
        $display("test t_deep done");
    endtask
    task automatic t_irq();
        rd_reg(SBW_IDX_IRQ_STAT);
        chk("events logged", 32'h7, rd & 32'h7);
        wr(SBW_IDX_IRQ_MASK, 32'h1);
        chk("irq unmasked", 32'h1, 32'(irq));
        wr(SBW_IDX_IRQ_MASK, 32'h8);
        wr(SBW_IDX_IRQ_STAT, 32'hf);
        chk("irq masked", 32'h0, 32'(irq));
        wake_pin <= 4'he;
        repeat (5) @(posedge aclk);
        chk("irq pin event", 32'h1, 32'(irq));
        rd_reg(SBW_IDX_WAKE_FLAG);
        chk("pin flag", 32'h1, rd);
        wr(SBW_IDX_IRQ_STAT, 32'h8);
        chk("irq cleared", 32'h0, 32'(irq));
        $display("test t_irq done");
    endtask
    task automatic t_switch();
        wr(SBW_IDX_STBY_CTRL, {19'h0, SBW_SETTLE_CODE_262K, 8'h0});
        sleep_go();
        repeat (3) @(posedge aclk);
        chk("sleep entered", 32'h1, 32'(status.sleeping));
        nmi_pin <= 1'b0;
        repeat (5) @(posedge aclk);
        chk("sleep woke", 32'h1, 32'(status.run));
        @(posedge aclk);
        do_switch <= 1'b1;
        @(posedge aclk);
        do_switch <= 1'b0;
        measure(WS);
        $display("test t_switch done");
    endtask
    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
        {do_sleep, do_switch, pend} = '0;
        {awaddr, wdata, araddr} = '0;
        nmi_pin = 1'b1;
        wake_pin = 4'hf;
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        t_regs();
        t_standby();
        t_deep();
        t_irq();
        t_switch();
        conclude();
    end
endmodule // tb
